// file: tb_top.sv
// bench: register reads and writes against the port control top
`timescale 1ns/1ps
module tb_top
  import usbplc_pkg::*;
;
  logic clk, rst;
  usbplc_req_t cpu_req, ext_req;
  usbplc_resp_t cpu_resp, ext_resp;
  logic [1:0] port_select, host_role;
  logic [1:0][1:0] far_en;
  usbplc_line_t [1:0][1:0] line_in, far_val;
  usbplc_port_out_t [1:0][1:0] port_out;
  usbplc_port_out_t p;
  logic e, s, h, rs;
  logic [15:0] a, d;
  logic [3:0] x;
  int n_errors = 0;
  int checks_done = 0;

  always #12.5 clk = ~clk;

  usbplc_top DUT (.clk(clk), .rst(rst), .cpu_req(cpu_req),
    .cpu_resp(cpu_resp), .ext_req(ext_req), .ext_resp(ext_resp),
    .port_select(port_select), .line_in(line_in), .port_out(port_out),
    .host_role(host_role));
  usbplc_cable_model u_cable (.clk(clk), .pins(port_out), .far_en(far_en),
    .far_val(far_val), .line(line_in));

  task automatic conclude;
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] ex);
    checks_done++;
    if (got !== ex) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, ex);
    end
  endtask
  task automatic chk_pin(input logic [3:0] got, input logic [3:0] ex);
    chk({12'h0, got}, {12'h0, ex});
  endtask
  task automatic put(input logic xp, input usbplc_req_t q);
    if (xp) ext_req <= q;
    else cpu_req <= q;
  endtask
  task automatic wr(input logic xp, input logic [15:0] ad, wd);
    put(xp, '{1'b1, 1'b0, ad, wd});
    @(posedge clk);
    put(xp, '0);
    @(posedge clk);
  endtask
  task automatic rd(input logic xp, input logic [15:0] ad, ex, input m);
    usbplc_resp_t r;
    bit got;
    got = 0;
    put(xp, '{1'b0, 1'b1, ad, 16'h0000});
    @(posedge clk);
    put(xp, '0);
    for (int n = 0; n < 4 && !got; n++) begin
      @(negedge clk);
      r = xp ? ext_resp : cpu_resp;
      got = r.rvalid === 1'b1;
    end
    if (!got) begin
      n_errors++;
      conclude();
    end
    chk(r.rdata, ex);
    chk({15'h0, r.miss}, {15'h0, m});
    @(posedge clk);
  endtask

  initial begin
    clk = 0;
    rst = 1;
    cpu_req = '0;
    ext_req = '0;
    port_select = '0;
    far_en = '1;
    far_val = 8'hB6;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(0, 16'hC08A, {far_val[0][1], far_val[0][0], 12'h000}, 0);
    rd(1, 16'hC0AA, {far_val[1][1], far_val[1][0], 12'h000}, 0);
    for (int i = 0; i < 16; i++) begin
      e = i[3];
      s = i[2];
      h = i[1];
      rs = i[0];
      a = e ? 16'hC0AA : 16'hC08A;
      d = ({15'h0, s} << (10 + e)) | ({15'h0, h} << 9)
        | ({15'h0, rs} << (7 + e));
      x = !rs ? 4'h0 : h ? 4'h3 : s ? 4'h4 : 4'h8;
      wr(e, a, d);
      @(posedge clk);
      @(negedge clk);
      p = port_out[e][e];
      chk_pin({p.pu_dp, p.pu_dm, p.pd_dp, p.pd_dm}, x);
      chk_pin({3'h0, host_role[e]}, {3'h0, h});
      @(posedge clk);
      rd(e, a, {far_val[e][1], far_val[e][0], d[11:0]}, 0);
    end
    wr(1, 16'hC08C, 16'h0FFF);
    rd(1, 16'hC0AA, {far_val[1][1], far_val[1][0], 12'hB00}, 0);
    rd(0, 16'hC08C, 16'h0000, 1);
    rd(1, 16'hC08C, 16'h0000, 1);
    put(0, '{1'b1, 1'b0, 16'hC0AA, 16'h0004});
    put(1, '{1'b1, 1'b0, 16'hC0AA, 16'h0008});
    @(posedge clk);
    put(0, '0);
    put(1, '0);
    @(posedge clk);
    rd(1, 16'hC0AA, {far_val[1][1], far_val[1][0], 12'h004}, 0);
    port_select <= 2'b01;
    for (int i = 0; i < 8; i++) begin
      d = {5'h0, i[2], 5'h0, i[1:0], 3'h0};
      x = i[1:0] == 2'h0 ? 4'h0 : i[1:0] == 2'h2 ? 4'h4
        : (i[1:0] == 2'h1) ^ i[2] ? 4'h6 : 4'h5;
      wr(0, 16'hC08A, d);
      @(posedge clk);
      @(negedge clk);
      p = port_out[0][0];
      chk_pin({1'b0, p.drv_oe, p.drv_dp, p.drv_dm}, x);
      @(posedge clk);
    end
    for (int k = 0; k < 2; k++) begin
      wr(0, 16'hC08A, k ? 16'h0407 : 16'h0607);
      @(posedge clk);
      @(negedge clk);
      p = port_out[0][0];
      x = k ? 4'h2 : 4'h7;
      chk_pin({p.sof_en, p.eop_en, p.suspend, p.active}, x);
      p = port_out[0][1];
      x = k ? 4'h3 : 4'hB;
      chk_pin({p.sof_en, p.eop_en, p.suspend, p.active}, x);
      @(posedge clk);
    end
    far_en <= '0;
    wr(0, 16'hC08A, 16'h0200);
    wr(0, 16'hC08A, 16'hF380);
    @(posedge clk);
    rd(0, 16'hC08A, 16'h0380, 0);
    conclude();
  end
endmodule

// file: usbplc_access.sv
// usbplc one register access path: decode and registered read
`timescale 1ns/1ps
`include "usbplc_params.svh"

module usbplc_access
  import usbplc_pkg::*;
#(
  parameter int NUM_ENG = 2
)
(
  input wire logic clk,
  input wire logic rst,
  input usbplc_req_t req,
  input wire logic [NUM_ENG-1:0][15:0] reg_val,
  output logic [NUM_ENG-1:0] wr_hit,
  output usbplc_resp_t resp
);

  localparam logic [1:0][15:0] OFFS = {`USBPLC_OFF_ENG1, `USBPLC_OFF_ENG0};

  typedef struct packed {
    usbplc_resp_t r;
  } usbplc_acc_state_t;

  usbplc_acc_state_t st_r;
  usbplc_acc_state_t st_nxt;
  logic [NUM_ENG-1:0] hit;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_ENG; i++) begin
      hit[i] = (req.addr == OFFS[i]); // R1
    end
  end

  assign wr_hit = hit & {NUM_ENG{req.wr}};

  // ------------------------------------------------------------
  // read answer, one cycle after the request
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = '0;
    st_nxt.r.rvalid = req.rd;
    st_nxt.r.rdata = `USBPLC_RDATA_RST;
    // unmapped reads answer zero and flag a miss
    st_nxt.r.miss = req.rd & ~(|hit);
    for (int i = 0; i < NUM_ENG; i++) begin
      if (req.rd && hit[i]) begin
        st_nxt.r.rdata = reg_val[i]; // R12
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign resp = st_r.r;

endmodule

// file: usbplc_cable_model.sv
// cable side: line levels from the far party, pulls and forced drive
`timescale 1ns/1ps
module usbplc_cable_model
  import usbplc_pkg::*;
(
  input wire logic clk,
  input usbplc_port_out_t [1:0][1:0] pins,
  input wire logic [1:0][1:0] far_en,
  input usbplc_line_t [1:0][1:0] far_val,
  output usbplc_line_t [1:0][1:0] line
);
  usbplc_line_t [1:0][1:0] last_r;
  always_ff @(posedge clk) begin
    last_r <= line;
  end
  always_comb begin
    for (int e = 0; e < 2; e++) begin
      for (int q = 0; q < 2; q++) begin
        // a floating line toggles so a stale level cannot pass
        line[e][q] = ~last_r[e][q];
        if (pins[e][q].pu_dp || pins[e][q].pd_dp) begin
          line[e][q].dp = pins[e][q].pu_dp;
        end
        if (pins[e][q].pu_dm || pins[e][q].pd_dm) begin
          line[e][q].dm = pins[e][q].pu_dm;
        end
        if (far_en[e][q]) begin
          line[e][q] = far_val[e][q];
        end
        if (pins[e][q].drv_oe) begin
          line[e][q] = {pins[e][q].drv_dp, pins[e][q].drv_dm};
        end
      end
    end
  end
endmodule

// file: usbplc_params.svh
// usbplc register offsets, field positions, reset values
`ifndef USBPLC_PARAMS_SVH
`define USBPLC_PARAMS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define USBPLC_OFF_ENG0 16'hC08A
`define USBPLC_OFF_ENG1 16'hC0AA

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define USBPLC_B_B_DP 15
`define USBPLC_B_B_DM 14
`define USBPLC_B_A_DP 13
`define USBPLC_B_A_DM 12
`define USBPLC_B_B_SLOW 11
`define USBPLC_B_A_SLOW 10
`define USBPLC_B_HOST 9
`define USBPLC_B_B_RES 8
`define USBPLC_B_A_RES 7
`define USBPLC_B_B_FRC_HI 6
`define USBPLC_B_B_FRC_LO 5
`define USBPLC_B_A_FRC_HI 4
`define USBPLC_B_A_FRC_LO 3
`define USBPLC_B_SUSP 2
`define USBPLC_B_B_MARK 1
`define USBPLC_B_A_MARK 0
`define USBPLC_CTL_MSB 11

// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define USBPLC_CTL_RST 12'h000
`define USBPLC_RDATA_RST 16'h0000
`define USBPLC_FRC_NORMAL 2'h0
`define USBPLC_FRC_SE0 2'h2
`define USBPLC_FRC_J 2'h1
`define USBPLC_FRC_K 2'h3

`endif

// file: usbplc_pkg.sv
// usbplc shared types
package usbplc_pkg;

  // live level of one port's data pair
  typedef struct packed {
    logic dp;
    logic dm;
  } usbplc_line_t;

  // one register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } usbplc_req_t;

  // registered read answer
  typedef struct packed {
    logic rvalid;
    logic miss;
    logic [15:0] rdata;
  } usbplc_resp_t;

  // per-port pin and control outputs
  typedef struct packed {
    logic pu_dp;
    logic pu_dm;
    logic pd_dp;
    logic pd_dm;
    logic drv_oe;
    logic drv_dp;
    logic drv_dm;
    logic sof_en;
    logic eop_en;
    logic active;
    logic suspend;
  } usbplc_port_out_t;

  // per-port settings taken from the control register and the port select input
  typedef struct packed {
    logic host;
    logic slow;
    logic res_en;
    logic [1:0] force_code;
    logic mark_en;
    logic suspend;
    logic selected;
  } usbplc_port_cfg_t;

endpackage

// file: usbplc_port.sv
// usbplc one port: termination, line force, frame marker enables
`timescale 1ns/1ps
`include "usbplc_params.svh"

module usbplc_port
  import usbplc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input usbplc_port_cfg_t cfg,
  output usbplc_port_out_t port_out
);

  typedef struct packed {
    usbplc_port_out_t o;
  } usbplc_port_state_t;

  usbplc_port_state_t st_r;
  usbplc_port_state_t st_nxt;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = '0;
    // resistors: gate off all, host pulls both down, device one up
    if (cfg.res_en) begin // R7 R8
      if (cfg.host) begin
        st_nxt.o.pd_dp = 1'b1; // R9
        st_nxt.o.pd_dm = 1'b1; // R9
      end else if (cfg.slow) begin
        st_nxt.o.pu_dm = 1'b1; // R10
      end else begin
        st_nxt.o.pu_dp = 1'b1; // R11
      end
    end
    // line force ignores port selection; J/K polarity follows speed
    case (cfg.force_code) // R13
      `USBPLC_FRC_SE0: begin
        st_nxt.o.drv_oe = 1'b1;
      end
      `USBPLC_FRC_J: begin
        st_nxt.o.drv_oe = 1'b1;
        st_nxt.o.drv_dp = ~cfg.slow;
        st_nxt.o.drv_dm = cfg.slow;
      end
      `USBPLC_FRC_K: begin
        st_nxt.o.drv_oe = 1'b1;
        st_nxt.o.drv_dp = cfg.slow;
        st_nxt.o.drv_dm = ~cfg.slow;
      end
      default: begin
        st_nxt.o.drv_oe = 1'b0;
      end
    endcase
    // device role serves only the selected port
    st_nxt.o.active = cfg.host | cfg.selected; // R6
    // markers only in host role; kind follows speed
    if (cfg.host && cfg.mark_en) begin // R15
      st_nxt.o.sof_en = ~cfg.slow;
      st_nxt.o.eop_en = cfg.slow;
    end
    st_nxt.o.suspend = cfg.suspend; // R14
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign port_out = st_r.o;

endmodule

// file: usbplc_top.sv
// usbplc top: two engines' port control registers and port logic
//
// Operation
// [R1] two identical port control registers, one per engine, at 0xC08A/0xC0AA
// [R2] bits 15..12 read live levels of B D+, B D-, A D+, A D-
// [R3] bit 11 set gives port B low speed, clear gives full speed
// [R4] bit 10 set gives port A low speed, clear gives full speed
// [R5] bit 9 set gives host role, clear gives device role
// [R6] device role serves one port, chosen by the companion port select bit
// [R7] bit 8 clear turns off every port B pull-up and pull-down
// [R8] bit 7 clear turns off every port A pull-up and pull-down
// [R9] enabled host port pulls both data lines down, whatever speed
// [R10] enabled low-speed device port pulls only D- up
// [R11] enabled full-speed device port pulls only D+ up
// [R12] register read and written from internal and external processor ports
// [R13] force fields 6:5 B, 4:3 A: normal, SE0, J, K, selection-independent
// [R14] bit 2 suspends both transceivers; wakeup monitoring continues
// [R15] host bits 1/0 enable SOF (full speed) or EOP (low speed) markers
// [R16] reset clears control bits 11..0; status bits follow lines
// [R17] software sets speed and role before enabling resistors
`timescale 1ns/1ps
`include "usbplc_params.svh"

module usbplc_top
  import usbplc_pkg::*;
#(
  parameter int NUM_ENG = 2
)
(
  input wire logic clk,
  input wire logic rst,
  // internal processor register port
  input usbplc_req_t cpu_req,
  output usbplc_resp_t cpu_resp,
  // external_processor_port register access
  input usbplc_req_t ext_req,
  output usbplc_resp_t ext_resp,
  // per engine: port select from the companion count register, 1 = port B
  input wire logic [NUM_ENG-1:0] port_select,
  // live line levels, index [engine][0=A,1=B]
  input usbplc_line_t [NUM_ENG-1:0][1:0] line_in,
  // per-port pin controls, index [engine][0=A,1=B]
  output usbplc_port_out_t [NUM_ENG-1:0][1:0] port_out,
  // per engine role, 1 = host
  output logic [NUM_ENG-1:0] host_role
);

  localparam int CW = `USBPLC_CTL_MSB + 1;

  typedef struct packed {
    logic [NUM_ENG-1:0][CW-1:0] ctl;
    logic [NUM_ENG-1:0] host;
  } usbplc_top_state_t;

  usbplc_top_state_t st_r;
  usbplc_top_state_t st_nxt;

  logic [NUM_ENG-1:0] cpu_wr_hit;
  logic [NUM_ENG-1:0] ext_wr_hit;
  logic [NUM_ENG-1:0][15:0] reg_val;
  usbplc_port_cfg_t [NUM_ENG-1:0][1:0] cfg;

  // ------------------------------------------------------------
  // register access paths
  // ------------------------------------------------------------
  usbplc_access #(.NUM_ENG(NUM_ENG)) u_cpu_acc (
    .clk(clk),
    .rst(rst),
    .req(cpu_req),
    .reg_val(reg_val),
    .wr_hit(cpu_wr_hit),
    .resp(cpu_resp)
  );

  usbplc_access #(.NUM_ENG(NUM_ENG)) u_ext_acc (
    .clk(clk),
    .rst(rst),
    .req(ext_req),
    .reg_val(reg_val),
    .wr_hit(ext_wr_hit),
    .resp(ext_resp)
  );

  // ------------------------------------------------------------
  // read value: live line levels above the stored control bits
  // ------------------------------------------------------------
  always_comb begin
    for (int e = 0; e < NUM_ENG; e++) begin
      reg_val[e] = {line_in[e][1].dp, line_in[e][1].dm,
                    line_in[e][0].dp, line_in[e][0].dm, // R2
                    st_r.ctl[e]};
    end
  end

  // ------------------------------------------------------------
  // control register update
  // ------------------------------------------------------------
  // status bits 15..12 are never stored, so writes to them fall away
  always_comb begin
    st_nxt = st_r;
    for (int e = 0; e < NUM_ENG; e++) begin
      // a same-cycle clash resolves to the internal processor
      if (cpu_wr_hit[e]) begin
        st_nxt.ctl[e] = cpu_req.wdata[CW-1:0]; // R12
      end else if (ext_wr_hit[e]) begin
        st_nxt.ctl[e] = ext_req.wdata[CW-1:0]; // R12
      end
      st_nxt.host[e] = st_nxt.ctl[e][`USBPLC_B_HOST]; // R5
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int e = 0; e < NUM_ENG; e++) begin
        st_r.ctl[e] <= `USBPLC_CTL_RST; // R16
      end
      st_r.host <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign host_role = st_r.host;

  // ------------------------------------------------------------
  // per-port settings and port logic
  // ------------------------------------------------------------
  // termination follows the stored register, so an order of writes
  // that sets speed and role first never shows a wrong pull to the
  // cable; a single write changing all at once switches in one edge
  always_comb begin
    for (int e = 0; e < NUM_ENG; e++) begin
      cfg[e][0].host = st_r.ctl[e][`USBPLC_B_HOST];
      cfg[e][1].host = st_r.ctl[e][`USBPLC_B_HOST];
      cfg[e][0].slow = st_r.ctl[e][`USBPLC_B_A_SLOW]; // R4
      cfg[e][1].slow = st_r.ctl[e][`USBPLC_B_B_SLOW]; // R3
      cfg[e][0].res_en = st_r.ctl[e][`USBPLC_B_A_RES]; // R8
      cfg[e][1].res_en = st_r.ctl[e][`USBPLC_B_B_RES]; // R7
      cfg[e][0].force_code =
        st_r.ctl[e][`USBPLC_B_A_FRC_HI:`USBPLC_B_A_FRC_LO]; // R13
      cfg[e][1].force_code =
        st_r.ctl[e][`USBPLC_B_B_FRC_HI:`USBPLC_B_B_FRC_LO]; // R13
      cfg[e][0].mark_en = st_r.ctl[e][`USBPLC_B_A_MARK]; // R15
      cfg[e][1].mark_en = st_r.ctl[e][`USBPLC_B_B_MARK]; // R15
      cfg[e][0].suspend = st_r.ctl[e][`USBPLC_B_SUSP]; // R14
      cfg[e][1].suspend = st_r.ctl[e][`USBPLC_B_SUSP]; // R14
      cfg[e][0].selected = ~port_select[e]; // R6
      cfg[e][1].selected = port_select[e]; // R6
    end
  end

  for (genvar e = 0; e < NUM_ENG; e++) begin : g_eng
    for (genvar p = 0; p < 2; p++) begin : g_port
      usbplc_port u_port (
        .clk(clk),
        .rst(rst),
        .cfg(cfg[e][p]),
        .port_out(port_out[e][p])
      );
    end
  end

endmodule

// file: usbplc_top_properties.sv
// assertions on the port control top
`timescale 1ns/1ps
module usbplc_top_chk
  import usbplc_pkg::*;
#(
  parameter int NUM_ENG = 2
)
(
  input wire logic clk,
  input wire logic rst,
  input usbplc_req_t cpu_req,
  input usbplc_resp_t cpu_resp,
  input usbplc_req_t ext_req,
  input usbplc_resp_t ext_resp,
  input wire logic [NUM_ENG-1:0] port_select,
  input usbplc_line_t [NUM_ENG-1:0][1:0] line_in,
  input usbplc_port_out_t [NUM_ENG-1:0][1:0] port_out,
  input wire logic [NUM_ENG-1:0] host_role
);
  usbplc_port_out_t a0, b0;
  assign a0 = port_out[0][0];
  assign b0 = port_out[0][1];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence rd0_s;
    cpu_req.rd && cpu_req.addr == 16'hC08A;
  endsequence
  sequence miss_s;
    ext_req.rd && ext_req.addr != 16'hC08A && ext_req.addr != 16'hC0AA;
  endsequence
  read_answer_a: assert property (cpu_req.rd |=> cpu_resp.rvalid)
    else $error("read not answered");
  quiet_bus_a: assert property (!ext_req.rd |=> !ext_resp.rvalid)
    else $error("answer without read");
  unmapped_read_a: assert property (
    miss_s |=> ext_resp.miss && ext_resp.rdata == 16'h0000)
    else $error("unmapped read gave data");
  line_status_a: assert property (
    rd0_s |=> cpu_resp.rdata[15:12] == $past({line_in[0][1], line_in[0][0]}))
    else $error("status bits differ from lines");
  host_pulls_a: assert property (
    host_role[0] |=> !a0.pu_dp && !a0.pu_dm && a0.pd_dp == a0.pd_dm)
    else $error("host port pulls wrong");
  one_pullup_a: assert property (!(b0.pu_dp && b0.pu_dm))
    else $error("both pull-ups on");
  no_marks_a: assert property (
    !host_role[0] |=> !(a0.sof_en || a0.eop_en || b0.sof_en || b0.eop_en))
    else $error("frame marker in device role");
  suspend_both_a: assert property (a0.suspend == b0.suspend)
    else $error("ports differ in suspend");
  dev_select_a: assert property (
    !host_role[0] |=> b0.active == $past(port_select[0])
      && a0.active != $past(port_select[0]))
    else $error("wrong active port");
  host_active_a: assert property (
    host_role[0] |=> a0.active && b0.active)
    else $error("host port inactive");
endmodule

bind usbplc_top usbplc_top_chk #(.NUM_ENG(NUM_ENG)) u_chk (
  .clk(clk), .rst(rst), .cpu_req(cpu_req), .cpu_resp(cpu_resp),
  .ext_req(ext_req), .ext_resp(ext_resp), .port_select(port_select),
  .line_in(line_in), .port_out(port_out), .host_role(host_role));
